// File: include/host_ctl_pkg.sv
package host_ctl_pkg;
    // ---------------------------------------------------------------
    // register map (word offsets are byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_PULSE     = 8'h08;
    localparam logic [7:0] ADDR_GPIO_DIR  = 8'h0C;
    localparam logic [7:0] ADDR_GPIO_OUT  = 8'h10;
    localparam logic [7:0] ADDR_LED       = 8'h14;
    localparam logic [7:0] ADDR_WDOG      = 8'h18;
    localparam logic [7:0] ADDR_BOOT      = 8'h1C;
    localparam logic [7:0] ADDR_PKT       = 8'h20;

    // ---------------------------------------------------------------
    // ctrl register fields
    // ---------------------------------------------------------------
    localparam int CTRL_PWR_INV_BIT = 0;
    localparam int CTRL_RST_INV_BIT = 1;
    localparam int CTRL_PWR_CMD_BIT = 2;
    localparam int CTRL_RST_CMD_BIT = 3;
    localparam int CTRL_KEY_OFF_BIT = 4;
    localparam int CTRL_KEY_ON_BIT  = 5;
    localparam int CTRL_KEY_RST_BIT = 6;
    localparam int CTRL_BLANK_BIT   = 7;

    // ---------------------------------------------------------------
    // widths, counts, reset values
    // ---------------------------------------------------------------
    localparam int GPIO_COUNT = 5;
    localparam int LED_COUNT  = 8;
    localparam int CLK_MHZ    = 100;
    localparam int PULSE_MS_DEFAULT = 200;
    localparam int PULSE_CYCLES_DEFAULT = PULSE_MS_DEFAULT * CLK_MHZ * 1000;
    localparam logic [7:0]  CMD_SWITCH_FN = 8'h1C;
    localparam logic [7:0]  CMD_SAVE_BOOT = 8'h04;
    localparam logic [7:0]  BOOT_RESET    = 8'h00;
    localparam logic [7:0]  SWITCH_ALL_ON = 8'hF0;
    localparam logic [4:0]  MAX_DATA_LEN  = 5'h16;
    localparam logic [15:0] CRC_INIT      = 16'hFFFF;
    localparam logic [15:0] CRC_POLY_REV  = 16'h8408;

    typedef enum logic [2:0] {
        PK_TYPE  = 3'b000,
        PK_LEN   = 3'b001,
        PK_DATA  = 3'b010,
        PK_CRCL  = 3'b011,
        PK_CRCH  = 3'b100
    } pkt_state_t;
endpackage

// File: design/switch_pulser.sv
`timescale 1ns/1ns
`default_nettype none
module switch_pulser (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // request and setup
    input  wire logic        fire_in,
    input  wire logic        invert_in,
    input  wire logic [31:0] width_in,
    // line drive
    output logic             drive_out,
    output logic             oe_out,
    output logic             busy_out
);
    import host_ctl_pkg::*;

    logic [31:0] count_q;

    // one pulse at a time; a request while busy is dropped
    // (R15) configurable width
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            count_q <= 32'h0000_0000;
        end else if (count_q != 32'h0000_0000) begin
            count_q <= count_q - 32'h0000_0001;
        end else if (fire_in) begin
            count_q <= (width_in == 32'h0000_0000) ? 32'h0000_0001 : width_in;
        end
    end

    // asserted level: low by default, high when inverted; released otherwise
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            drive_out <= 1'b0;
        end else begin
            drive_out <= invert_in;
        end
    end

    assign oe_out   = (count_q != 32'h0000_0000);
    assign busy_out = oe_out;

    // drive only during the pulse, released at count zero
    chk_release_after: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (count_q == 32'h0000_0001) |=> !oe_out) else $error("line not released"); // (R15)
    chk_pulse_start: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!oe_out && fire_in) |=> oe_out) else $error("pulse not started"); // (R15)
endmodule
`default_nettype wire

// File: design/host_power_reset.sv
// Operation
// (R01) five general-purpose lines each selectable as input or output; the direction register reaches only lines 3 and 4.
// (R02) eight output-only lines drive the front-panel indicators.
// (R03) no fourth fan drive or tach; those pins carry serial data.
// (R04) line one is a host-power sense input, high when host supply is up; the code takes the sense from line zero.
// (R05) behaviour depends on whether sensed host power is on or off.
// (R06) power-switch line is released (input) except while commanding.
// (R07) power command drives the switch line briefly at the chosen polarity.
// (R08) reset line is released (input) except while resetting the host.
// (R09) reset drives the reset line briefly at the chosen polarity.
// (R10) a watchdog expiry also pulses the host reset line.
// (R11) software keeps the three host-control lines in default mode.
// (R12) switch-function command 28 with byte 240 enables all four keypad/blank functions.
// (R13) command 4 with no data saves the configuration as boot state.
// (R14) commands arrive as type, length, data, and a 16-bit check value.
// (R15) the pulse width is configurable and the line is released after it.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module host_power_reset (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    // keypad requests (same clock)
    input  wire logic        key_power_in,
    input  wire logic        key_reset_in,
    // general-purpose lines
    input  wire logic [host_ctl_pkg::GPIO_COUNT-1:0] gpio_in,
    output logic [host_ctl_pkg::GPIO_COUNT-1:0]      gpio_out,
    output logic [host_ctl_pkg::GPIO_COUNT-1:0]      gpio_oe_out,
    // indicators and display
    output logic [host_ctl_pkg::LED_COUNT-1:0]       output_only_line,
    output logic             display_blank_out
);
    import host_ctl_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [31:0] pulse_q;
    logic [4:0]  dir_q;
    logic [4:0]  gout_q;
    logic [7:0]  led_q;
    logic [31:0] wdog_load_q;
    logic [31:0] wdog_cnt_q;
    logic [7:0]  boot_q;
    logic [4:0]  sync1_q;
    logic [4:0]  sync2_q;
    logic        pwr_fire;
    logic        rst_fire;
    logic        wdog_fire;
    logic        pwr_drv;
    logic        pwr_oe;
    logic        pwr_busy;
    logic        rst_drv;
    logic        rst_oe;
    logic        rst_busy;
    logic        host_on;
    logic        pkt_cmd_pwr;
    logic        pkt_cmd_rst;
    // packet parser
    pkt_state_t  pst_q;
    logic [7:0]  ptype_q;
    logic [4:0]  plen_q;
    logic [4:0]  pidx_q;
    logic [7:0]  pdata0_q;
    logic [15:0] pcrc_q;
    logic [7:0]  pcrcl_q;
    logic        pkt_err_q;
    logic        pkt_ok_q;
    logic        pkt_wr;

    // crc-16 byte step, reflected polynomial
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // pin input synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= gpio_in;
            sync2_q <= sync1_q;
        end
    end

    // (R04) power sense on line zero
    assign host_on = sync2_q[0];

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    assign pkt_wr = wr_in && (addr_in == ADDR_PKT);

    // ctrl: polarities, one-shot commands and switch enables
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_q <= BOOT_RESET;
        end else if (wr_in && (addr_in == ADDR_CTRL)) begin
            ctrl_q <= wdata_in[7:0];
        end else if (pkt_ok_q && ptype_q == CMD_SWITCH_FN) begin
            // (R12) switch functions from packet
            ctrl_q <= {pdata0_q[7:4], 2'b00, ctrl_q[1:0]};
        end else begin
            ctrl_q[CTRL_PWR_CMD_BIT] <= 1'b0;
            ctrl_q[CTRL_RST_CMD_BIT] <= 1'b0;
        end
    end

    // boot image of the whole ctrl register, polarity bits included
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            boot_q <= BOOT_RESET;
        end else if (pkt_ok_q && ptype_q == CMD_SAVE_BOOT) begin
            // (R13) store as boot state
            boot_q <= ctrl_q;
        end else if (wr_in && (addr_in == ADDR_BOOT)) begin
            boot_q <= wdata_in[7:0];
        end
    end

    // remaining plain registers
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pulse_q     <= PULSE_CYCLES_DEFAULT;
            dir_q       <= 5'h00;
            gout_q      <= 5'h00;
            led_q       <= 8'h00;
            wdog_load_q <= 32'h0000_0000;
        end else if (wr_in) begin
            if (addr_in == ADDR_PULSE) begin
                pulse_q <= wdata_in;
            end else if (addr_in == ADDR_GPIO_DIR) begin
                dir_q <= wdata_in[4:0];
            end else if (addr_in == ADDR_GPIO_OUT) begin
                gout_q <= wdata_in[4:0];
            end else if (addr_in == ADDR_LED) begin
                led_q <= wdata_in[7:0];
            end else if (addr_in == ADDR_WDOG) begin
                wdog_load_q <= wdata_in;
            end
        end
    end

    // ---------------------------------------------------------------
    // watchdog: zero load disables; any write to it restarts
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdog_cnt_q <= 32'h0000_0000;
        end else if (wr_in && (addr_in == ADDR_WDOG)) begin
            wdog_cnt_q <= wdata_in;
        end else if (wdog_cnt_q != 32'h0000_0000) begin
            wdog_cnt_q <= wdog_cnt_q - 32'h0000_0001;
        end
    end

    // (R10) expiry fires the reset pulse
    assign wdog_fire = (wdog_cnt_q == 32'h0000_0001);

    // ---------------------------------------------------------------
    // packet receiver: bytes written to the packet register
    // ---------------------------------------------------------------
    // (R14) type, length, data, crc low then high
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pst_q     <= PK_TYPE;
            ptype_q   <= 8'h00;
            plen_q    <= 5'h00;
            pidx_q    <= 5'h00;
            pdata0_q  <= 8'h00;
            pcrc_q    <= CRC_INIT;
            pcrcl_q   <= 8'h00;
            pkt_ok_q  <= 1'b0;
            pkt_err_q <= 1'b0;
        end else begin
            pkt_ok_q <= 1'b0;
            if (pkt_wr) begin
                case (pst_q)
                    PK_TYPE: begin
                        ptype_q <= wdata_in[7:0];
                        pcrc_q  <= crc_step(CRC_INIT, wdata_in[7:0]);
                        pst_q   <= PK_LEN;
                    end
                    PK_LEN: begin
                        pcrc_q <= crc_step(pcrc_q, wdata_in[7:0]);
                        plen_q <= wdata_in[4:0];
                        pidx_q <= 5'h00;
                        if (wdata_in[7:0] > {3'b000, MAX_DATA_LEN}) begin
                            pkt_err_q <= 1'b1;
                            pst_q     <= PK_TYPE;
                        end else if (wdata_in[7:0] == 8'h00) begin
                            pst_q <= PK_CRCL;
                        end else begin
                            pst_q <= PK_DATA;
                        end
                    end
                    PK_DATA: begin
                        pcrc_q <= crc_step(pcrc_q, wdata_in[7:0]);
                        if (pidx_q == 5'h00) begin
                            pdata0_q <= wdata_in[7:0];
                        end
                        pidx_q <= pidx_q + 5'h01;
                        if (pidx_q + 5'h01 == plen_q) begin
                            pst_q <= PK_CRCL;
                        end
                    end
                    PK_CRCL: begin
                        pcrcl_q <= wdata_in[7:0];
                        pst_q   <= PK_CRCH;
                    end
                    default: begin
                        pst_q <= PK_TYPE;
                        if ({wdata_in[7:0], pcrcl_q} == pcrc_q) begin
                            pkt_ok_q  <= 1'b1;
                            pkt_err_q <= 1'b0;
                        end else begin
                            pkt_err_q <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    assign pkt_cmd_pwr = 1'b0;
    assign pkt_cmd_rst = 1'b0;

    // ---------------------------------------------------------------
    // power and reset requests
    // ---------------------------------------------------------------
    // (R05) keypad on only when host is off, keypad off only when on
    assign pwr_fire = ctrl_q[CTRL_PWR_CMD_BIT] || pkt_cmd_pwr ||
                      (key_power_in && host_on && ctrl_q[CTRL_KEY_OFF_BIT]) ||
                      (key_power_in && !host_on && ctrl_q[CTRL_KEY_ON_BIT]);
    assign rst_fire = ctrl_q[CTRL_RST_CMD_BIT] || pkt_cmd_rst || wdog_fire ||
                      (key_reset_in && host_on && ctrl_q[CTRL_KEY_RST_BIT]);

    // (R07) power switch pulse
    switch_pulser pwr_pulse (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .fire_in    (pwr_fire),
        .invert_in  (ctrl_q[CTRL_PWR_INV_BIT]),
        .width_in   (pulse_q),
        .drive_out  (pwr_drv),
        .oe_out     (pwr_oe),
        .busy_out   (pwr_busy)
    );

    // (R09) reset switch pulse
    switch_pulser rst_pulse (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .fire_in    (rst_fire),
        .invert_in  (ctrl_q[CTRL_RST_INV_BIT]),
        .width_in   (pulse_q),
        .drive_out  (rst_drv),
        .oe_out     (rst_oe),
        .busy_out   (rst_busy)
    );

    // ---------------------------------------------------------------
    // line drive; lines 1 and 2 belong to the pulsers
    // ---------------------------------------------------------------
    // (R01) user direction on lines 3 and 4; (R04) sense never driven
    // (R06) (R08) control lines released outside a pulse
    always_comb begin
        gpio_out    = gout_q;
        gpio_oe_out = dir_q;
        gpio_oe_out[0] = 1'b0;
        gpio_out[1]    = pwr_drv;
        gpio_oe_out[1] = pwr_oe;
        gpio_out[2]    = rst_drv;
        gpio_oe_out[2] = rst_oe;
    end

    // (R02) indicators straight from register
    assign output_only_line = led_q;

    // (R12) blank display while host is down
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            display_blank_out <= 1'b0;
        end else begin
            display_blank_out <= ctrl_q[CTRL_BLANK_BIT] && !host_on;
        end
    end

    // ---------------------------------------------------------------
    // read port, data one cycle after the strobe; unmapped reads zero
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_out <= 32'h0000_0000;
        end else if (rd_in) begin
            if (addr_in == ADDR_CTRL) begin
                rdata_out <= {24'h000000, ctrl_q};
            end else if (addr_in == ADDR_STATUS) begin
                rdata_out <= {24'h000000, pkt_err_q, 2'b00, sync2_q};
            end else if (addr_in == ADDR_PULSE) begin
                rdata_out <= pulse_q;
            end else if (addr_in == ADDR_GPIO_DIR) begin
                rdata_out <= {27'h0000000, dir_q};
            end else if (addr_in == ADDR_GPIO_OUT) begin
                rdata_out <= {27'h0000000, gout_q};
            end else if (addr_in == ADDR_LED) begin
                rdata_out <= {24'h000000, led_q};
            end else if (addr_in == ADDR_WDOG) begin
                rdata_out <= wdog_cnt_q;
            end else if (addr_in == ADDR_BOOT) begin
                rdata_out <= {24'h000000, boot_q};
            end else begin
                rdata_out <= 32'h0000_0000;
            end
        end else begin
            rdata_out <= 32'h0000_0000;
        end
    end

    // (R03) no fan-four logic exists in this variant

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_sense_never_driven: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !gpio_oe_out[0]) else $error("sense line driven"); // (R04)
    chk_pwr_polarity: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        gpio_oe_out[1] |-> gpio_out[1] == $past(ctrl_q[CTRL_PWR_INV_BIT])) else $error("power level wrong"); // (R07)
    chk_rst_polarity: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        gpio_oe_out[2] |-> gpio_out[2] == $past(ctrl_q[CTRL_RST_INV_BIT])) else $error("reset level wrong"); // (R09)
    chk_pwr_released: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!pwr_busy && !pwr_fire) |=> !gpio_oe_out[1]) else $error("power line held"); // (R06)
    chk_rst_released: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (!rst_busy && !rst_fire) |=> !gpio_oe_out[2]) else $error("reset line held"); // (R08)
    chk_wdog_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wdog_fire && !rst_busy) |=> gpio_oe_out[2]) else $error("watchdog no reset"); // (R10)
    chk_switch_cmd: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pkt_ok_q && ptype_q == CMD_SWITCH_FN && pdata0_q == SWITCH_ALL_ON && !wr_in)
        |=> ctrl_q[7:4] == 4'hF) else $error("switch enables not set"); // (R12)
    chk_save_boot: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (pkt_ok_q && ptype_q == CMD_SAVE_BOOT) |=> boot_q == $past(ctrl_q)) else $error("boot not saved"); // (R13)
    chk_blank_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (ctrl_q[CTRL_BLANK_BIT] && !host_on) |=> display_blank_out) else $error("display not blanked"); // (R05)
    cov_power_pulse: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(gpio_oe_out[1]));
    cov_reset_pulse: cover property (@(posedge clk_in) disable iff (sys_rst_in) $rose(gpio_oe_out[2]));
    cov_packet_ok: cover property (@(posedge clk_in) disable iff (sys_rst_in) pkt_ok_q);
endmodule
`default_nettype wire

// File: verification/host_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_board_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // pins seen from the board
    input  wire logic [4:0] gpio_out_in,
    input  wire logic [4:0] gpio_oe_in,
    input  wire logic       press_level_in,
    // board side
    output logic [4:0]      gpio_in_out,
    output logic            host_on_out,
    output logic [7:0]      reset_count_out
);
    logic pwr_press;
    logic rst_press;
    logic pwr_q;
    logic rst_q;
    logic flip_q;
    // a press is only the device driving the active level, so idle pull-ups never count
    assign pwr_press = gpio_oe_in[1] && (gpio_out_in[1] == press_level_in);
    assign rst_press = gpio_oe_in[2] && (gpio_out_in[2] == press_level_in);
    assign gpio_in_out[0] = host_on_out;
    // default drive mode: switch inputs idle at the not-pressed level
    assign gpio_in_out[1] = gpio_oe_in[1] ? gpio_out_in[1] : ~press_level_in;
    assign gpio_in_out[2] = gpio_oe_in[2] ? gpio_out_in[2] : ~press_level_in;
    // user lines float when released, so a changing pattern stands in for the unknown
    assign gpio_in_out[4:3] = {gpio_oe_in[4] ? gpio_out_in[4] : flip_q, gpio_oe_in[3] ? gpio_out_in[3] : ~flip_q};
    // host acts when the switch is let go
    always @(posedge clk_in) begin
        flip_q <= ~flip_q & ~sys_rst_in;
        pwr_q <= pwr_press;
        rst_q <= rst_press;
        if (sys_rst_in) begin
            host_on_out <= 1'b0;
            reset_count_out <= 8'h00;
        end else begin
            if (pwr_q && !pwr_press) host_on_out <= ~host_on_out;
            if (rst_q && !rst_press) reset_count_out <= reset_count_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: verification/host_power_reset_test.sv
`timescale 1ns/1ns
`default_nettype none
module host_power_reset_test;
    import host_ctl_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic key_power_in = 1'b0;
    logic key_reset_in = 1'b0;
    logic [4:0] gpio_in;
    logic [4:0] gpio_out;
    logic [4:0] gpio_oe_out;
    logic [7:0] output_only_line;
    logic display_blank_out;
    logic press_level = 1'b0;
    logic host_on;
    logic [7:0] resets;
    logic [31:0] rv;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 clk_in = ~clk_in;
    host_power_reset u_host_power_reset (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .key_power_in(key_power_in),
        .key_reset_in(key_reset_in), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe_out),
        .output_only_line(output_only_line), .display_blank_out(display_blank_out));
    host_board_model u_host_board_model (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .gpio_out_in(gpio_out),
        .gpio_oe_in(gpio_oe_out), .press_level_in(press_level), .gpio_in_out(gpio_in),
        .host_on_out(host_on), .reset_count_out(resets));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    // waits a bounded time for the line to be driven, then times the drive
    task automatic pulse(input int ln, input logic lvl, input int width, input int wait_max);
        int n;
        int w;
        n = 0;
        w = 0;
        #1;
        while (gpio_oe_out[ln] !== 1'b1 && w < wait_max) begin
            @(posedge clk_in);
            #1;
            w++;
        end
        while (gpio_oe_out[ln] === 1'b1 && n < width + 5) begin
            check("drive level", {31'h0, lvl}, {31'h0, gpio_out[ln]});
            @(posedge clk_in);
            #1;
            n++;
        end
        check("drive width", 32'(width), 32'(n));
    endtask
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
        return r;
    endfunction
    task automatic send(input logic [7:0] typ, input logic [7:0] len, input logic [7:0] d0, input logic good);
        logic [15:0] c;
        c = crc_step(crc_step(CRC_INIT, typ), len);
        if (len != 8'h00) c = crc_step(c, d0);
        if (!good) c = c ^ 16'h00FF;
        wr(ADDR_PKT, {24'h0, typ});
        wr(ADDR_PKT, {24'h0, len});
        if (len != 8'h00) wr(ADDR_PKT, {24'h0, d0});
        wr(ADDR_PKT, {24'h0, c[7:0]});
        wr(ADDR_PKT, {24'h0, c[15:8]});
        repeat (3) @(posedge clk_in);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_idle();
        rd(ADDR_PULSE, rv);
        check("pulse reset", 32'(PULSE_CYCLES_DEFAULT), rv);
        rd(8'h24, rv);
        check("unmapped", 32'h0, rv);
        check("oe idle", 32'h0, {27'h0, gpio_oe_out});
        wr(ADDR_LED, 32'h000000A5);
        wr(ADDR_GPIO_DIR, 32'h0000001F);
        wr(ADDR_GPIO_OUT, 32'h0000001F);
        #1;
        check("leds", 32'hA5, {24'h0, output_only_line});
        check("user oe", 32'h18, {27'h0, gpio_oe_out & gpio_out});
        check("host lines free", 32'h0, {29'h0, gpio_oe_out[2:0]});
        wr(ADDR_PULSE, 32'h00000014);
        $display("test idle done");
    endtask
    task automatic t_power(input logic inv, input logic on);
        press_level <= inv;
        wr(ADDR_CTRL, {28'h0, 4'h4 | {3'h0, inv}});
        pulse(1, inv, 20, 10);
        rd(ADDR_CTRL, rv);
        check("cmd self clear", 32'h0, {31'h0, rv[2]});
        rd(ADDR_STATUS, rv);
        check("power sense", {31'h0, on}, {31'h0, rv[0]});
        $display("test power done");
    endtask
    task automatic t_reset(input logic inv, input logic [7:0] n);
        press_level <= inv;
        wr(ADDR_CTRL, {28'h0, 4'h8 | {2'h0, inv, 1'b0}});
        pulse(2, inv, 20, 10);
        // the host counts the press one edge after the line is let go
        @(posedge clk_in);
        #1;
        check("host reset", {24'h0, n}, {24'h0, resets});
        press_level <= 1'b0;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_WDOG, 32'd30);
        pulse(2, 1'b0, 20, 100);
        wr(ADDR_WDOG, 32'h0);
        check("watchdog reset", {24'h0, n + 8'h01}, {24'h0, resets});
        $display("test reset done");
    endtask
    task automatic t_packets();
        send(CMD_SWITCH_FN, 8'h01, SWITCH_ALL_ON, 1'b1);
        rd(ADDR_CTRL, rv);
        // polarity bits survive the switch command; power invert is still set
        check("switch enables", 32'hF1, {24'h0, rv[7:0]});
        send(CMD_SAVE_BOOT, 8'h00, 8'h00, 1'b1);
        rd(ADDR_BOOT, rv);
        check("boot image", 32'hF1, {24'h0, rv[7:0]});
        send(CMD_SAVE_BOOT, 8'h00, 8'h00, 1'b0);
        rd(ADDR_STATUS, rv);
        check("bad check value", 32'h1, {31'h0, rv[7]});
        send(CMD_SAVE_BOOT, 8'h00, 8'h00, 1'b1);
        rd(ADDR_STATUS, rv);
        check("error cleared", 32'h0, {31'h0, rv[7]});
        $display("test packets done");
    endtask
    task automatic t_keys();
        check("blank host off", 32'h1, {31'h0, display_blank_out});
        @(posedge clk_in);
        key_reset_in <= 1'b1;
        @(posedge clk_in);
        key_reset_in <= 1'b0;
        pulse(2, 1'b0, 0, 30);
        @(posedge clk_in);
        key_power_in <= 1'b1;
        @(posedge clk_in);
        key_power_in <= 1'b0;
        pulse(1, 1'b1, 20, 10);
        repeat (6) @(posedge clk_in);
        #1;
        check("unblank host on", 32'h0, {31'h0, display_blank_out});
        $display("test keys done");
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_idle();
        t_power(1'b0, 1'b1);
        t_reset(1'b1, 8'h01);
        t_power(1'b1, 1'b0);
        t_packets();
        t_keys();
        summarize();
    end
endmodule
`default_nettype wire
